// ===== src/hdt_pkg.sv
// constants, register map and symbol kinds for the hdlc data link transmitter
package hdt_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] HDT_IDX_CFG = 8'h34;
    localparam logic [7:0] HDT_IDX_STAT = 8'h35;
    localparam logic [7:0] HDT_IDX_TDR = 8'h36;
    localparam logic [7:0] HDT_IDX_OPT = 8'h37;
    localparam logic [7:0] HDT_ADDR_CFG = {HDT_IDX_CFG[5:0], 2'b00};
    localparam logic [7:0] HDT_ADDR_STAT = {HDT_IDX_STAT[5:0], 2'b00};
    localparam logic [7:0] HDT_ADDR_TDR = {HDT_IDX_TDR[5:0], 2'b00};
    localparam logic [7:0] HDT_ADDR_OPT = {HDT_IDX_OPT[5:0], 2'b00};
    // configuration field positions
    localparam int HDT_CFG_EN = 0;
    localparam int HDT_CFG_CRC = 1;
    localparam int HDT_CFG_ABORT = 2;
    localparam int HDT_CFG_GATE = 3;
    localparam int HDT_CFG_LAST = 4;
    // status field positions
    localparam int HDT_STAT_UDR = 0;
    localparam int HDT_STAT_REQ = 1;
    // options field position
    localparam int HDT_OPT_ROUTE = 0;
    // reset values
    localparam logic [4:0] HDT_CFG_RST = 5'h00;
    localparam logic [7:0] HDT_TDR_RST = 8'h00;
    localparam logic [15:0] HDT_CRC_PRESET = 16'hFFFF;
    // crc-16 polynomial x^16 + x^12 + x^5 + 1
    localparam logic [15:0] HDT_CRC_POLY = 16'h1021;
    // symbols, sent lsb first
    localparam logic [7:0] HDT_FLAG = 8'h7E;
    localparam logic [7:0] HDT_ABORT = 8'h7F;
    localparam logic [7:0] HDT_ONES = 8'hFF;
    localparam logic [2:0] HDT_STUFF_RUN = 3'h5;
    // data link bit period
    localparam int HDT_CLK_NS = 20;
    localparam int HDT_BIT_NS = 160;
    localparam logic [7:0] HDT_BIT_CYCLES = 8'(HDT_BIT_NS / HDT_CLK_NS);
    // axi responses
    localparam logic [1:0] HDT_RESP_OKAY = 2'h0;
    localparam logic [1:0] HDT_RESP_SLVERR = 2'h2;
    // symbol being serialized
    typedef enum logic [2:0] {
        HDT_SYM_OFF,
        HDT_SYM_FLAG,
        HDT_SYM_DATA,
        HDT_SYM_FCS,
        HDT_SYM_ABORT,
        HDT_SYM_UDR_ABORT,
        HDT_SYM_UDR_FLAG,
        HDT_SYM_IDLE
    } hdt_sym_t;
endpackage

// ===== src/hdt_transmitter.sv
// hdlc data link transmitter with axi4-lite register slave
//
// Contract
// - enable sends flags until data; clear disables
// - crc enable appends 16-bit check sequence
// - crc polynomial x16+x12+x5+1
// - check sequence sent msb first
// - abort request repeats 11111110 after last byte
// - irq gate masks link transmit interrupt
// - routing enable mirrors interrupt on host_irq_n
// - last-byte mark: checksum then flags follow
// - last-byte mark self-clears before next packet
// - byte request set when byte enters shifter
// - byte request zero while byte held
// - byte request independent of irq gate
// - underrun set when shifter empties unfed
// - underrun: one abort, flag, then wait
// - underrun still set: send all ones
// - underrun cleared only by writing zero
// - data bytes sent lsb first
// - byte needed: raise irq and request flag
`timescale 1ns/1ns
module hdt_transmitter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic link_tx_bit,
    output logic link_tx_bit_en,
    output logic link_tx_irq_out,
    output logic host_irq_n
);
    // register select: 0 none, 1 config, 2 status, 3 data, 4 options
    function automatic logic [2:0] hdt_decode(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        if (addr == hdt_pkg::HDT_ADDR_CFG) sel = 3'h1;
        if (addr == hdt_pkg::HDT_ADDR_STAT) sel = 3'h2;
        if (addr == hdt_pkg::HDT_ADDR_TDR) sel = 3'h3;
        if (addr == hdt_pkg::HDT_ADDR_OPT) sel = 3'h4;
        return sel;
    endfunction

    // one crc step on a bit in line order
    function automatic logic [15:0] hdt_crc_step(input logic [15:0] crc, input logic b);
        return {crc[14:0], 1'b0} ^ ((b ^ crc[15]) ? hdt_pkg::HDT_CRC_POLY : 16'h0000);
    endfunction

    logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_lane_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [4:0] cfg_reg;
    logic [7:0] tdr_reg;
    logic route_reg, hold_full_reg, udr_reg, in_pkt_reg;
    logic [7:0] div_reg;
    logic [15:0] sh_reg, crc_reg;
    logic [3:0] cnt_reg;
    logic [2:0] ones_reg;
    logic bit_reg, bit_en_reg, irq_reg, host_irq_n_reg;
    hdt_pkg::hdt_sym_t sym_reg, sym_next;

    // axi write and read channel decode
    wire aw_take = awvalid && awready_reg;
    wire w_take = wvalid && wready_reg;
    wire wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
    wire [2:0] wr_sel = hdt_decode(aw_addr_reg);
    wire wr_ok = wr_do && (wr_sel != 3'h0);
    wire wr_cfg = wr_ok && w_lane_reg && (wr_sel == 3'h1);
    wire wr_stat = wr_ok && w_lane_reg && (wr_sel == 3'h2);
    wire wr_tdr = wr_ok && w_lane_reg && (wr_sel == 3'h3);
    wire wr_opt = wr_ok && w_lane_reg && (wr_sel == 3'h4);
    wire aw_full_next = wr_do ? 1'b0 : (aw_full_reg || aw_take);
    wire w_full_next = wr_do ? 1'b0 : (w_full_reg || w_take);
    wire bvalid_next = wr_do || (bvalid_reg && !bready);
    wire ar_take = arvalid && arready_reg;
    wire rvalid_next = ar_take || (rvalid_reg && !rready);
    wire [2:0] rd_sel = hdt_decode(araddr);

    // register views
    wire en = cfg_reg[hdt_pkg::HDT_CFG_EN];
    wire crc_on = cfg_reg[hdt_pkg::HDT_CFG_CRC];
    wire abort_request = cfg_reg[hdt_pkg::HDT_CFG_ABORT];
    wire tx_irq_gate = cfg_reg[hdt_pkg::HDT_CFG_GATE];
    wire packet_last_byte_mark = cfg_reg[hdt_pkg::HDT_CFG_LAST];
    wire byte_req = !hold_full_reg;
    wire [7:0] stat_view = {6'h00, byte_req, udr_reg};
    wire [31:0] rd_view = (rd_sel == 3'h1) ? {27'h0, cfg_reg} :
                          (rd_sel == 3'h2) ? {24'h0, stat_view} :
                          (rd_sel == 3'h3) ? {24'h0, tdr_reg} :
                          (rd_sel == 3'h4) ? {31'h0, route_reg} : 32'h0000_0000;

    // serializer timing and bit selection
    wire tick = (div_reg == 8'h00);
    wire stuffed_kind = (sym_reg == hdt_pkg::HDT_SYM_DATA) || (sym_reg == hdt_pkg::HDT_SYM_FCS);
    wire stuff_now = tick && stuffed_kind && (ones_reg == hdt_pkg::HDT_STUFF_RUN);
    wire load_now = tick && !stuff_now && (cnt_reg == 4'h0);
    wire gap = !hold_full_reg && in_pkt_reg && (sym_reg == hdt_pkg::HDT_SYM_DATA);

    // choose the next symbol at a symbol boundary
    always_comb
    begin
        sym_next = hdt_pkg::HDT_SYM_FLAG;
        if (!en)
            sym_next = hdt_pkg::HDT_SYM_OFF;
        else if (sym_reg == hdt_pkg::HDT_SYM_UDR_ABORT)
            sym_next = hdt_pkg::HDT_SYM_UDR_FLAG;
        else if ((sym_reg == hdt_pkg::HDT_SYM_UDR_FLAG || sym_reg == hdt_pkg::HDT_SYM_IDLE)
                 && udr_reg)
            sym_next = hdt_pkg::HDT_SYM_IDLE;
        // repeat aborts once no byte waits
        else if (abort_request && !hold_full_reg)
            sym_next = hdt_pkg::HDT_SYM_ABORT;
        else if (hold_full_reg && sym_reg != hdt_pkg::HDT_SYM_OFF
                 && sym_reg != hdt_pkg::HDT_SYM_FCS && sym_reg != hdt_pkg::HDT_SYM_ABORT)
            sym_next = hdt_pkg::HDT_SYM_DATA;
        // last byte: check sequence or flags
        else if (gap && packet_last_byte_mark)
            sym_next = crc_on ? hdt_pkg::HDT_SYM_FCS : hdt_pkg::HDT_SYM_FLAG;
        // shifter emptied without a new byte
        else if (gap)
            sym_next = hdt_pkg::HDT_SYM_UDR_ABORT;
    end

    // complement, bit-reversed so msb leaves first
    wire [15:0] fcs_word = {<<{~crc_reg}};
    wire [15:0] load_word = (sym_next == hdt_pkg::HDT_SYM_DATA) ? {8'h00, tdr_reg} :
                            (sym_next == hdt_pkg::HDT_SYM_FCS) ? fcs_word :
                            (sym_next == hdt_pkg::HDT_SYM_ABORT
                             || sym_next == hdt_pkg::HDT_SYM_UDR_ABORT) ?
                                {8'h00, hdt_pkg::HDT_ABORT} :
                            (sym_next == hdt_pkg::HDT_SYM_OFF
                             || sym_next == hdt_pkg::HDT_SYM_IDLE) ?
                                {8'h00, hdt_pkg::HDT_ONES} : {8'h00, hdt_pkg::HDT_FLAG};
    wire [3:0] load_len = (sym_next == hdt_pkg::HDT_SYM_FCS) ? 4'hF : 4'h7;
    wire out_bit = stuff_now ? 1'b0 : (load_now ? load_word[0] : sh_reg[0]);
    wire data_bit = tick && !stuff_now &&
                    (load_now ? (sym_next == hdt_pkg::HDT_SYM_DATA)
                              : (sym_reg == hdt_pkg::HDT_SYM_DATA));
    wire [15:0] crc_base = (load_now && !in_pkt_reg) ? hdt_pkg::HDT_CRC_PRESET : crc_reg;
    wire load_data = load_now && (sym_next == hdt_pkg::HDT_SYM_DATA);
    wire end_pkt = load_now && gap && packet_last_byte_mark && en;
    wire stuff_next_kind = load_now ?
        (sym_next == hdt_pkg::HDT_SYM_DATA || sym_next == hdt_pkg::HDT_SYM_FCS) : stuffed_kind;
    wire [2:0] ones_inc = (ones_reg == hdt_pkg::HDT_STUFF_RUN) ? 3'h0 : ones_reg + 3'h1;
    // axi handshake state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {aw_full_reg, w_full_reg, awready_reg, wready_reg,
             bvalid_reg, arready_reg, rvalid_reg} <= 7'h00;
        else
        begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= !aw_full_next && !bvalid_next;
            wready_reg <= !w_full_next && !bvalid_next;
            bvalid_reg <= bvalid_next;
            rvalid_reg <= rvalid_next;
            arready_reg <= !rvalid_next;
        end
    end

    // axi payload latches
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {aw_addr_reg, w_data_reg, w_lane_reg, bresp_reg, rresp_reg, rdata_reg} <= 53'h0;
        else
        begin
            if (aw_take) aw_addr_reg <= awaddr;
            if (w_take) w_data_reg <= wdata[7:0];
            if (w_take) w_lane_reg <= wstrb[0];
            if (wr_do) bresp_reg <= wr_ok ? hdt_pkg::HDT_RESP_OKAY : hdt_pkg::HDT_RESP_SLVERR;
            if (ar_take) rdata_reg <= rd_view;
            if (ar_take)
                rresp_reg <= (rd_sel != 3'h0) ? hdt_pkg::HDT_RESP_OKAY : hdt_pkg::HDT_RESP_SLVERR;
        end
    end

    // software registers, holding byte and underrun flag
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_reg <= hdt_pkg::HDT_CFG_RST;
            tdr_reg <= hdt_pkg::HDT_TDR_RST;
            {route_reg, hold_full_reg, udr_reg} <= 3'h0;
        end
        else
        begin
            // mark cleared as the packet closes; a write wins
            if (wr_cfg) cfg_reg <= w_data_reg[4:0];
            else if (end_pkt) cfg_reg[hdt_pkg::HDT_CFG_LAST] <= 1'b0;
            if (wr_tdr) tdr_reg <= w_data_reg;
            if (wr_opt) route_reg <= w_data_reg[hdt_pkg::HDT_OPT_ROUTE];
            // request follows the shifter load; a new write wins
            if (wr_tdr) hold_full_reg <= 1'b1;
            else if (load_data || !en) hold_full_reg <= 1'b0;
            // set wins; only a written zero clears
            if (load_now && sym_next == hdt_pkg::HDT_SYM_UDR_ABORT) udr_reg <= 1'b1;
            else if (wr_stat && !w_data_reg[hdt_pkg::HDT_STAT_UDR]) udr_reg <= 1'b0;
        end
    end

    // bit divider and serializer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_reg <= 8'h00;
            sym_reg <= hdt_pkg::HDT_SYM_OFF;
            {sh_reg, crc_reg} <= {16'h0000, hdt_pkg::HDT_CRC_PRESET};
            {cnt_reg, ones_reg, in_pkt_reg} <= 8'h00;
        end
        else
        begin
            div_reg <= tick ? hdt_pkg::HDT_BIT_CYCLES - 8'h01 : div_reg - 8'h01;
            if (load_now)
            begin
                sym_reg <= sym_next;
                sh_reg <= {1'b0, load_word[15:1]};
                cnt_reg <= load_len;
                in_pkt_reg <= (sym_next == hdt_pkg::HDT_SYM_DATA);
            end
            else if (tick && !stuff_now)
            begin
                sh_reg <= {1'b0, sh_reg[15:1]};
                cnt_reg <= cnt_reg - 4'h1;
            end
            if (tick) ones_reg <= (stuff_next_kind && out_bit && !stuff_now) ? ones_inc : 3'h0;
            if (data_bit) crc_reg <= hdt_crc_step(crc_base, out_bit);
        end
    end

    // registered link and interrupt outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {bit_reg, bit_en_reg, irq_reg, host_irq_n_reg} <= 4'h9; // idle ones, host pin high
        else
        begin
            bit_en_reg <= tick;
            if (tick) bit_reg <= out_bit;
            irq_reg <= tx_irq_gate && en && byte_req;
            host_irq_n_reg <= !(route_reg && tx_irq_gate && en && byte_req);
        end
    end
    assign {awready, wready, bvalid, bresp} = {awready_reg, wready_reg, bvalid_reg, bresp_reg};
    assign {arready, rvalid, rresp, rdata} = {arready_reg, rvalid_reg, rresp_reg, rdata_reg};
    assign {link_tx_bit, link_tx_bit_en} = {bit_reg, bit_en_reg};
    assign {link_tx_irq_out, host_irq_n} = {irq_reg, host_irq_n_reg};
    // checks on serializer and flags
    property p_off_ones;
        @(posedge aclk) disable iff (!aresetn)
        tick && !stuff_now && sym_reg == hdt_pkg::HDT_SYM_OFF && !load_now |=> link_tx_bit;
    endproperty
    a_off_ones: assert property (p_off_ones) else $error("disabled link not idle ones");
    property p_fcs_follows;
        @(posedge aclk) disable iff (!aresetn)
        load_now && gap && en && packet_last_byte_mark && crc_on && !abort_request
        |=> sym_reg == hdt_pkg::HDT_SYM_FCS && cnt_reg == 4'hF;
    endproperty
    a_fcs_follows: assert property (p_fcs_follows) else $error("fcs not appended");
    property p_abort_repeat;
        @(posedge aclk) disable iff (!aresetn)
        load_now && en && abort_request && !hold_full_reg && !udr_reg
        && sym_reg != hdt_pkg::HDT_SYM_UDR_ABORT |=> sym_reg == hdt_pkg::HDT_SYM_ABORT;
    endproperty
    a_abort_repeat: assert property (p_abort_repeat) else $error("abort not sent");
    property p_gate_mask;
        @(posedge aclk) disable iff (!aresetn)
        !tx_irq_gate ##1 1 |-> !link_tx_irq_out && host_irq_n;
    endproperty
    a_gate_mask: assert property (p_gate_mask) else $error("interrupt not masked");
    property p_route;
        @(posedge aclk) disable iff (!aresetn)
        1 ##1 1 |-> host_irq_n == !($past(route_reg) && link_tx_irq_out);
    endproperty
    a_route: assert property (p_route) else $error("host pin not mirroring");
    property p_mark_clear;
        @(posedge aclk) disable iff (!aresetn)
        end_pkt && !wr_cfg |=> !packet_last_byte_mark;
    endproperty
    a_mark_clear: assert property (p_mark_clear) else $error("last mark not cleared");
    property p_req_set;
        @(posedge aclk) disable iff (!aresetn)
        load_data && !wr_tdr |=> byte_req && sym_reg == hdt_pkg::HDT_SYM_DATA;
    endproperty
    a_req_set: assert property (p_req_set) else $error("byte request not set");
    property p_req_clr;
        @(posedge aclk) disable iff (!aresetn)
        wr_tdr |=> !byte_req;
    endproperty
    a_req_clr: assert property (p_req_clr) else $error("request high with byte held");
    property p_udr_seq;
        @(posedge aclk) disable iff (!aresetn)
        load_now && en && sym_reg == hdt_pkg::HDT_SYM_UDR_ABORT && udr_reg
        && !(wr_stat && !w_data_reg[hdt_pkg::HDT_STAT_UDR])
        |=> sym_reg == hdt_pkg::HDT_SYM_UDR_FLAG && udr_reg;
    endproperty
    a_udr_seq: assert property (p_udr_seq) else $error("no flag after underrun abort");
    property p_udr_hold;
        @(posedge aclk) disable iff (!aresetn)
        udr_reg && !(wr_stat && !w_data_reg[0]) |=> udr_reg;
    endproperty
    a_udr_hold: assert property (p_udr_hold) else $error("underrun cleared wrongly");
    property p_stuff;
        @(posedge aclk) disable iff (!aresetn)
        stuff_now |=> !link_tx_bit ##0 $stable(cnt_reg);
    endproperty
    a_stuff: assert property (p_stuff) else $error("stuffed bit not zero");
endmodule

// ===== verification/hdt_link_sink.sv
// far-side framer model: collects the serial data link bits
`timescale 1ns/1ns
module hdt_link_sink (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_tx_bit,
    input wire logic link_tx_bit_en,
    output logic [63:0] rx_bits
);
    // newest bit enters at the top, so lsb-first bytes read in order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_bits <= 64'h0;
        else if (link_tx_bit_en)
            rx_bits <= {link_tx_bit, rx_bits[63:1]};
    end
endmodule

// ===== verification/tb_hdt_transmitter.sv
// self-checking bench for the hdlc data link transmitter
`timescale 1ns/1ns
module tb_hdt_transmitter;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic link_tx_bit, link_tx_bit_en, link_tx_irq_out, host_irq_n;
    logic [63:0] rx_bits, e, m;
    int n_fail = 0;
    int tests_run = 0;

    hdt_transmitter hdt_transmitter_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .link_tx_bit(link_tx_bit), .link_tx_bit_en(link_tx_bit_en),
        .link_tx_irq_out(link_tx_irq_out), .host_irq_n(host_irq_n));
    hdt_link_sink hdt_link_sink_inst (.aclk(aclk), .aresetn(aresetn),
        .link_tx_bit(link_tx_bit), .link_tx_bit_en(link_tx_bit_en), .rx_bits(rx_bits));

    // 50 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // axi4-lite write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is released at the edge that takes it
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    // axi4-lite read
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // expected line bits: flag, stuffed data and check sequence, raw 16-bit tail
    task automatic frame(input logic [15:0] b, input int nb, input logic crc,
                         input logic [15:0] tail);
        bit p[$];
        bit q[$];
        logic [15:0] c;
        logic [7:0] f;
        int ones;
        c = 16'hFFFF;
        f = 8'h7E;
        ones = 0;
        e = '0;
        m = '0;
        for (int k = 0; k < 8; k++) q.push_back(f[k]);
        for (int k = 0; k < 8 * nb; k++)
        begin
            p.push_back(b[k]);
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0000);
        end
        if (crc)
            for (int k = 15; k >= 0; k--) p.push_back(~c[k]);
        foreach (p[i])
        begin
            q.push_back(p[i]);
            ones = p[i] ? ones + 1 : 0;
            if (ones == 5)
            begin
                q.push_back(1'b0);
                ones = 0;
            end
        end
        for (int k = 0; k < 16; k++) q.push_back(tail[k]);
        foreach (q[i])
        begin
            e[64 - q.size() + i] = q[i];
            m[64 - q.size() + i] = 1'b1;
        end
    endtask

    // wait for the expected bits to show at the far side, bounded
    task automatic see_line();
        for (int i = 0; i < 3000 && (rx_bits & m) !== e; i++) @(posedge aclk);
        chk(rx_bits & m, e);
    endtask

    task automatic see_tail(input logic [15:0] t);
        e = {t, 48'h0};
        m = {16'hFFFF, 48'h0};
        see_line();
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #1000000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and unmapped place
        rd(hdt_pkg::HDT_ADDR_CFG); chk(v, 32'h0);
        rd(hdt_pkg::HDT_ADDR_STAT); chk(v, 32'h2);
        rd(hdt_pkg::HDT_ADDR_OPT); chk(v, 32'h0);
        rd(8'h00); chk({v, r}, {32'h0, hdt_pkg::HDT_RESP_SLVERR});
        wr(8'h00, 32'h1, 4'hF); chk(r, hdt_pkg::HDT_RESP_SLVERR);
        // interrupt gating and routing
        wr(hdt_pkg::HDT_ADDR_CFG, 32'h01, 4'hF);
        repeat (2) @(posedge aclk);
        chk(link_tx_irq_out, 1'b0);
        rd(hdt_pkg::HDT_ADDR_STAT); chk(v, 32'h2);
        wr(hdt_pkg::HDT_ADDR_CFG, 32'h09, 4'hF);
        repeat (2) @(posedge aclk);
        chk({link_tx_irq_out, host_irq_n}, 2'b11);
        wr(hdt_pkg::HDT_ADDR_OPT, 32'h1, 4'hF);
        repeat (2) @(posedge aclk);
        chk(host_irq_n, 1'b0);
        wr(hdt_pkg::HDT_ADDR_OPT, 32'h0, 4'h0);
        rd(hdt_pkg::HDT_ADDR_OPT); chk(v, 32'h1);
        see_tail(16'h7E7E);
        // two-byte packet with check sequence
        wr(hdt_pkg::HDT_ADDR_CFG, 32'h0B, 4'hF);
        // write just after a flag has begun, well before the next symbol load
        for (int i = 0; i < 200 && rx_bits[63:56] !== 8'h7E; i++) @(posedge aclk);
        repeat (16) @(posedge aclk);
        wr(hdt_pkg::HDT_ADDR_TDR, 32'h12, 4'hF);
        rd(hdt_pkg::HDT_ADDR_STAT); chk(v, 32'h0);
        for (int i = 0; i < 100 && v[1] !== 1'b1; i++) rd(hdt_pkg::HDT_ADDR_STAT);
        chk(v, 32'h2);
        wr(hdt_pkg::HDT_ADDR_TDR, 32'h34, 4'hF);
        wr(hdt_pkg::HDT_ADDR_CFG, 32'h1B, 4'hF);
        frame(16'h3412, 2, 1'b1, 16'h7E7E);
        see_line();
        // next packet finds the mark cleared at the last close, then runs dry
        wr(hdt_pkg::HDT_ADDR_TDR, 32'h5A, 4'hF);
        for (int i = 0; i < 100 && v[1] !== 1'b1; i++) rd(hdt_pkg::HDT_ADDR_STAT);
        rd(hdt_pkg::HDT_ADDR_CFG); chk(v, 32'h0B);
        frame(16'h005A, 1, 1'b0, 16'h7E7F);
        see_line();
        see_tail(16'hFFFF);
        rd(hdt_pkg::HDT_ADDR_STAT); chk(v, 32'h3);
        rd(hdt_pkg::HDT_ADDR_STAT); chk(v, 32'h3);
        wr(hdt_pkg::HDT_ADDR_STAT, 32'h3, 4'hF);
        rd(hdt_pkg::HDT_ADDR_STAT); chk(v, 32'h3);
        wr(hdt_pkg::HDT_ADDR_STAT, 32'h0, 4'hF);
        rd(hdt_pkg::HDT_ADDR_STAT); chk(v, 32'h2);
        see_tail(16'h7E7E);
        // abort request repeats after the last byte
        wr(hdt_pkg::HDT_ADDR_CFG, 32'h0D, 4'hF);
        wr(hdt_pkg::HDT_ADDR_TDR, 32'h21, 4'hF);
        frame(16'h0021, 1, 1'b0, 16'h7F7F);
        see_line();
        // disable sends all ones and drops the interrupt
        wr(hdt_pkg::HDT_ADDR_CFG, 32'h00, 4'hF);
        see_tail(16'hFFFF);
        chk({link_tx_irq_out, host_irq_n}, 2'b01);
        report_and_stop();
    end
endmodule
